// File: src/i2cmm_map.svh
// Purpose: Register offsets, field positions, reset values and timing counts of the two-wire bus interface.
// Assumes: Register port with a 4-bit word address and 8-bit data.
// Notes: Definitions only; included by bare name.
`ifndef I2CMM_MAP_SVH
`define I2CMM_MAP_SVH

// Register word addresses.
`define I2CMM_A_CTRL 4'h0
`define I2CMM_A_STAT1 4'h1
`define I2CMM_A_STAT2 4'h2
`define I2CMM_A_DATA 4'h3
`define I2CMM_A_OWN_LO 4'h4
`define I2CMM_A_OWN_HI 4'h5
`define I2CMM_A_GCA 4'h6
`define I2CMM_A_CCR 4'h7
`define I2CMM_A_ECCR 4'h8

// Control register fields; bit 7 is kept clear and reads as zero.
`define I2CMM_CR_ITE 0
`define I2CMM_CR_STOP 1
`define I2CMM_CR_ACK 2
`define I2CMM_CR_START 3
`define I2CMM_CR_GCEN 4
`define I2CMM_CR_ON 5
`define I2CMM_CR_DMA 6
`define I2CMM_CR_WMASK 8'h7f

// Second own-address register: bits 7:6 clock range, bit 3 ten-bit mode, bits 2:1 address bits 9:8.
`define I2CMM_OH_A10 3
// Clock divider register: bit 7 selects the fast rate floor.
`define I2CMM_CCR_FAST 7

// Reset value of every software register.
`define I2CMM_RST_BYTE 8'h00
// Ten-bit header prefix and the start byte that is never answered.
`define I2CMM_HDR10 5'h1e
`define I2CMM_START_BYTE 8'h01

// Bit rate limits and the derived least half period in system clocks (rounded up).
`define I2CMM_CLK_HZ 100000000
`define I2CMM_STD_HZ 100000
`define I2CMM_FAST_HZ 400000
`define I2CMM_STD_HALF ((`I2CMM_CLK_HZ + 2 * `I2CMM_STD_HZ - 1) / (2 * `I2CMM_STD_HZ))
`define I2CMM_FAST_HALF ((`I2CMM_CLK_HZ + 2 * `I2CMM_FAST_HZ - 1) / (2 * `I2CMM_FAST_HZ))

`endif

// File: src/i2cmm_pkg.sv
// Purpose: Types shared by the two-wire bus interface.
// Assumes: Constants come from i2cmm_map.svh.
// Notes: State enums carry no explicit codes.
package i2cmm_pkg;

	// Start and stop generator states.
	typedef enum logic [2:0] {G_IDLE, G_START_A, G_START_B, G_STOP_A, G_STOP_B} i2cmm_gen_t;

	// What software access releases a stretched clock.
	typedef enum logic [1:0] {W_NONE, W_SR1, W_WR, W_RD} i2cmm_wait_t;

endpackage

// File: src/i2cmm_line_sync.sv
// Purpose: Synchronise the bus lines and find clock edges and start and stop conditions.
// Assumes: Lines idle high through external pull-ups.
// Notes: The first flop of each chain feeds only the second.
`timescale 1ns/100ps
module i2cmm_line_sync (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sda_pin,
	input wire logic scl_pin,
	output logic sda_s,
	output logic scl_s,
	output logic scl_rise,
	output logic scl_fall,
	output logic start_det,
	output logic stop_det
);
	logic [2:0] sda_q;
	logic [2:0] scl_q;

	// Two stages of synchronisation plus one stage of history, reset to the idle high level.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sda_q <= 3'h7;
			scl_q <= 3'h7;
		end else begin
			sda_q <= {sda_q[1:0], sda_pin};
			scl_q <= {scl_q[1:0], scl_pin};
		end
	end

	// Edges only look at stages two and three, never at the metastable first stage.
	assign sda_s = sda_q[1];
	assign scl_s = scl_q[1];
	assign scl_rise = scl_q[1] & ~scl_q[2];
	assign scl_fall = ~scl_q[1] & scl_q[2];
	assign start_det = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1]; // [R24]
	assign stop_det = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1]; // [R24]
endmodule

// File: src/i2cmm_top.sv
// Purpose: Multimaster and slave two-wire bus interface behind a plain register port.
// Assumes: 100 MHz clk, synchronous active-low reset, open-drain pads resolved outside.
// Notes: Bus events are taken from synchronised line edges, so master and slave share one bit engine.
`timescale 1ns/100ps
`include "i2cmm_map.svh"

// Function
// R1: Standard up to 100 kHz, fast up to 400 kHz, rate set by divider.
// R2: When enabled, pins only pull low or release, never drive high.
// R3: When disabled, pins return to general-purpose port control.
// R4: Interface is disabled after reset.
// R5: Software sets own-address-high bits 7:6 for clock range before enabling.
// R6: Software keeps control bit 7 clear.
// R7: Slave by default, master after start, slave after arbitration loss or stop.
// R8: Master drives clock; start and stop only on software request.
// R9: Every transfer opens with start and closes with stop.
// R10: Slave recognises own 7/10-bit address and gated general call.
// R11: Start byte 01h is never answered.
// R12: General call from its register; own address from one or both registers.
// R13: Bytes shift eight bits, most significant first.
// R14: First byte (7-bit) or two bytes (10-bit) are address.
// R15: Ninth clock carries receiver acknowledge; software enables acknowledge.
// R16: Clock held low until data written before send or read after receive.
// R17: DMA request, wait for completion, then transfer on next clock rise.
// R18: Parallel-serial conversion, steps by interrupt or polled flags.
// R19: Enable bit written twice; first write only turns the interface on.
// R20: Address match sets flag, acknowledges, holds clock until status one read.
// R21: Start or stop inside a byte sets bus error and resets engine.
// R22: Arbitration loss sets lost and ack-failure flags, drops master, resets.
// R23: Master waits while clock stays low after release.
// R24: Start and stop found by data change while clock high, synchronised.
module i2cmm_top
	import i2cmm_pkg::*;
#(
	parameter int CNT_W = 12
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	input wire logic sda_in,
	input wire logic scl_in,
	output logic sda_out,
	output logic sda_oe,
	output logic scl_out,
	output logic scl_oe,
	input wire logic gpio_sda_out,
	input wire logic gpio_sda_oe,
	input wire logic gpio_scl_out,
	input wire logic gpio_scl_oe,
	output logic dma_req,
	input wire logic dma_ack,
	input wire logic [7:0] dma_wdata,
	output logic [7:0] dma_rdata,
	output logic event_irq
);
	// The divider is twelve bits wide; a narrower timer could not reach it.
	if (CNT_W < 12 || CNT_W > 16) begin : g_bad_width
		$error("CNT_W must lie between 12 and 16");
	end

	logic [7:0] ctrl_q, own_lo_q, own_hi_q, gca_q, ccr_q, eccr_q, dr_q, sh_q, rdata_q;
	logic [3:0] cnt_q;
	logic [CNT_W-1:0] tmr_q;
	logic busy_q, master_q, active_q, addr_ph_q, a10_stage_q, matched10_q, pend_q, tx_q, nack_q;
	logic hold_q, sda_low_q, gsda_low_q, gscl_low_q, dma_req_q, irq_q;
	logic sb_q, address_matched_flag_q, btf_q, af_q, stopf_q, arbitration_lost_flag_q, bus_error_flag_q, gcal_q;
	logic sda_oe_q, scl_oe_q, sda_out_q, scl_out_q;
	i2cmm_gen_t gen_q;
	i2cmm_wait_t wait_q;
	logic sda_s, scl_s, scl_rise, scl_fall, start_det, stop_det;

	i2cmm_line_sync u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.sda_pin(sda_in),
		.scl_pin(scl_in),
		.sda_s(sda_s),
		.scl_s(scl_s),
		.scl_rise(scl_rise),
		.scl_fall(scl_fall),
		.start_det(start_det),
		.stop_det(stop_det)
	);

	// Register port decode.
	wire wr_ctrl = reg_we && reg_addr == `I2CMM_A_CTRL;
	wire wr_dr = reg_we && reg_addr == `I2CMM_A_DATA;
	wire rd_sr1 = reg_re && reg_addr == `I2CMM_A_STAT1;
	wire rd_sr2 = reg_re && reg_addr == `I2CMM_A_STAT2;
	wire rd_dr = reg_re && reg_addr == `I2CMM_A_DATA;
	wire on = ctrl_q[`I2CMM_CR_ON];
	wire ack_en = ctrl_q[`I2CMM_CR_ACK];
	wire a10 = own_hi_q[`I2CMM_OH_A10];

	// Status words; the event summary is any pending flag except general call.
	wire evf = sb_q | address_matched_flag_q | btf_q | af_q | stopf_q | arbitration_lost_flag_q | bus_error_flag_q;
	wire [7:0] sr1 = {evf, tx_q, busy_q, btf_q, address_matched_flag_q, master_q, sb_q, hold_q};
	wire [7:0] sr2 = {3'h0, af_q, stopf_q, arbitration_lost_flag_q, bus_error_flag_q, gcal_q};
	wire [7:0] rd_val = reg_addr == `I2CMM_A_CTRL ? ctrl_q :
		reg_addr == `I2CMM_A_STAT1 ? sr1 :
		reg_addr == `I2CMM_A_STAT2 ? sr2 :
		reg_addr == `I2CMM_A_DATA ? dr_q :
		reg_addr == `I2CMM_A_OWN_LO ? own_lo_q :
		reg_addr == `I2CMM_A_OWN_HI ? own_hi_q :
		reg_addr == `I2CMM_A_GCA ? {1'b0, gca_q[6:0]} :
		reg_addr == `I2CMM_A_CCR ? ccr_q :
		reg_addr == `I2CMM_A_ECCR ? eccr_q : 8'h00;

	// The first enabling write sets only the enable bit; the rest is taken once it is on.
	wire [7:0] ctrl_wr = on ? (reg_wdata & `I2CMM_CR_WMASK) : (reg_wdata & 8'h20); // [R19]
	wire start_req = ctrl_q[`I2CMM_CR_START];
	wire stop_req = ctrl_q[`I2CMM_CR_STOP];
	wire gen_take_start = gen_q == G_IDLE && start_req && (!busy_q || (master_q && hold_q)); // [R8]
	wire gen_take_stop = gen_q == G_IDLE && !start_req && stop_req && master_q && hold_q; // [R8]
	wire [7:0] ctrl_clr = {4'h0, gen_take_start, 1'b0, gen_take_stop, 1'b0};

	// Half bit period: the divider, never shorter than the floor of the selected rate.
	wire [11:0] div_val = {eccr_q[4:0], ccr_q[6:0]};
	wire [11:0] half_min = ccr_q[`I2CMM_CCR_FAST] ? 12'(`I2CMM_FAST_HALF) : 12'(`I2CMM_STD_HALF); // [R1]
	wire [CNT_W-1:0] half = CNT_W'(div_val > half_min ? div_val : half_min); // [R1]
	wire tmr_done = tmr_q >= half;

	// Slave address comparison on the byte just shifted in.
	wire not_sb = sh_q != `I2CMM_START_BYTE; // [R11]
	wire hdr_ok = a10 && sh_q[7:3] == `I2CMM_HDR10 && sh_q[2:1] == own_hi_q[2:1];
	wire m_gc = ctrl_q[`I2CMM_CR_GCEN] && sh_q[7:1] == gca_q[6:0] && not_sb; // [R10] [R12]
	wire m_7 = !a10 && sh_q[7:1] == own_lo_q[7:1] && not_sb; // [R12]
	wire m_hw = hdr_ok && !sh_q[0] && !a10_stage_q;
	wire m_hr = hdr_ok && sh_q[0] && matched10_q;
	wire m_lo = a10 && a10_stage_q && sh_q == own_lo_q; // [R14]
	wire m_any = m_7 || m_gc || m_hr || m_lo;
	wire m_hdr_tx = a10 && sh_q[7:3] == `I2CMM_HDR10 && !sh_q[0];

	// Software or DMA access that ends a stretched clock.
	wire dma_en = ctrl_q[`I2CMM_CR_DMA];
	wire fill = hold_q && wait_q == W_WR && (wr_dr || (dma_en && dma_ack));
	wire drain = hold_q && wait_q == W_RD && (rd_dr || (dma_en && dma_ack));
	wire [7:0] fill_val = wr_dr ? reg_wdata : dma_wdata;
	wire arb_lost = scl_rise && active_q && master_q && tx_q && cnt_q < 4'h8 && !sda_low_q && !sda_s;

	// Software registers; reset leaves the interface off.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_q <= `I2CMM_RST_BYTE; // [R4]
			own_lo_q <= `I2CMM_RST_BYTE;
			own_hi_q <= `I2CMM_RST_BYTE;
			gca_q <= `I2CMM_RST_BYTE;
			ccr_q <= `I2CMM_RST_BYTE;
			eccr_q <= `I2CMM_RST_BYTE;
		end else begin
			ctrl_q <= (wr_ctrl ? ctrl_wr : ctrl_q) & ~ctrl_clr;
			if (reg_we && reg_addr == `I2CMM_A_OWN_LO) own_lo_q <= reg_wdata;
			if (reg_we && reg_addr == `I2CMM_A_OWN_HI) own_hi_q <= reg_wdata;
			if (reg_we && reg_addr == `I2CMM_A_GCA) gca_q <= reg_wdata;
			if (reg_we && reg_addr == `I2CMM_A_CCR) ccr_q <= reg_wdata;
			if (reg_we && reg_addr == `I2CMM_A_ECCR) eccr_q <= reg_wdata;
		end
	end

	// Bus engine, clock generator and flags; turning the interface off resets them like reset does, except that the data register keeps its value and stays writable.
	always_ff @(posedge clk) begin
		if (!rst_n || !on) begin
			{busy_q, master_q, active_q, addr_ph_q, a10_stage_q, matched10_q, pend_q, tx_q, nack_q} <= 9'h000;
			{hold_q, sda_low_q, gsda_low_q, gscl_low_q} <= 4'h0;
			{sb_q, address_matched_flag_q, btf_q, af_q, stopf_q, arbitration_lost_flag_q, bus_error_flag_q, gcal_q} <= 8'h00;
			sh_q <= 8'h00;
			cnt_q <= 4'h0;
			tmr_q <= '0;
			gen_q <= G_IDLE;
			wait_q <= W_NONE;
			if (!rst_n) dr_q <= `I2CMM_RST_BYTE;
			else if (wr_dr) dr_q <= reg_wdata;
		end else begin
			// Reading status two clears its flags; any set below in the same cycle wins.
			if (rd_sr2) {af_q, stopf_q, arbitration_lost_flag_q, bus_error_flag_q, gcal_q} <= 5'h00;
			if (wr_dr) dr_q <= reg_wdata;
			if (start_det) begin
				busy_q <= 1'b1;
				// The rise that opens a legal stop or repeated start counts as one bit, so only two to eight is misplaced.
				if (active_q && cnt_q > 4'h1 && cnt_q < 4'h9) bus_error_flag_q <= 1'b1; // [R21]
				{active_q, addr_ph_q, a10_stage_q, pend_q} <= 4'b1100; // [R14]
				cnt_q <= 4'h0;
				tx_q <= master_q;
			end else if (stop_det) begin
				busy_q <= 1'b0;
				if (active_q && cnt_q > 4'h1 && cnt_q < 4'h9) bus_error_flag_q <= 1'b1; // [R21]
				else if (active_q) stopf_q <= 1'b1;
				{active_q, master_q, matched10_q, hold_q, sda_low_q} <= 5'h00; // [R9]
				cnt_q <= 4'h0;
				wait_q <= W_NONE;
			end else if (arb_lost) begin
				{arbitration_lost_flag_q, af_q} <= 2'b11; // [R22]
				{master_q, active_q, hold_q, sda_low_q, gscl_low_q} <= 5'h00; // [R7] [R22]
				cnt_q <= 4'h0;
			end else if (scl_rise && active_q) begin
				if (cnt_q < 4'h8) sh_q <= {sh_q[6:0], sda_s}; // [R13]
				if (cnt_q == 4'h8) nack_q <= sda_s; // [R15]
				if (cnt_q == 4'h8 && tx_q && sda_s) af_q <= 1'b1;
				if (cnt_q < 4'h9) cnt_q <= cnt_q + 4'h1;
			end else if (scl_fall && active_q && !hold_q) begin
				if (cnt_q < 4'h8) begin
					sda_low_q <= tx_q & ~sh_q[7]; // [R2] [R13]
				end else if (cnt_q == 4'h8) begin
					// Ninth clock: the receiver drives acknowledge.
					if (addr_ph_q && !master_q) begin
						if (m_hw) begin
							a10_stage_q <= 1'b1;
							sda_low_q <= ack_en; // [R15]
						end else if (m_any) begin
							sda_low_q <= ack_en; // [R20]
							{address_matched_flag_q, pend_q} <= 2'b11; // [R20]
							gcal_q <= m_gc;
							tx_q <= m_hr || ((m_7 || m_gc) && sh_q[0]);
							matched10_q <= matched10_q | m_lo | m_hr;
						end else begin
							{active_q, sda_low_q} <= 2'b00; // [R10]
						end
					end else begin
						if (!tx_q) dr_q <= sh_q; // [R18]
						sda_low_q <= !tx_q && !addr_ph_q && ack_en; // [R15]
					end
				end else begin
					sda_low_q <= 1'b0;
					cnt_q <= 4'h0;
					hold_q <= 1'b1; // [R16]
					if (master_q && addr_ph_q) begin
						addr_ph_q <= a10 && m_hdr_tx && !a10_stage_q;
						a10_stage_q <= a10 && m_hdr_tx;
						tx_q <= ~sh_q[0] || (a10 && m_hdr_tx);
						wait_q <= (sh_q[0] && !m_hdr_tx) ? W_SR1 : W_WR;
					end else if (!master_q && addr_ph_q) begin
						addr_ph_q <= !pend_q;
						hold_q <= pend_q; // [R20]
						wait_q <= pend_q ? W_SR1 : W_NONE;
						pend_q <= 1'b0;
					end else if (tx_q && nack_q && !master_q) begin
						{hold_q, active_q} <= 2'b00;
						wait_q <= W_NONE;
					end else begin
						btf_q <= 1'b1; // [R18]
						wait_q <= tx_q ? W_WR : W_RD; // [R16]
					end
				end
			end else if (hold_q && wait_q == W_SR1 && rd_sr1) begin
				{address_matched_flag_q, sb_q} <= 2'b00; // [R20]
				hold_q <= tx_q;
				wait_q <= tx_q ? W_WR : W_NONE;
			end else if (fill) begin
				// Data loaded and its first bit placed while the clock is still low.
				sh_q <= fill_val;
				dr_q <= fill_val;
				sda_low_q <= ~fill_val[7]; // [R16]
				{hold_q, btf_q, sb_q, gsda_low_q} <= 4'h0; // [R17]
				wait_q <= W_NONE;
			end else if (drain) begin
				{hold_q, btf_q} <= 2'b00; // [R16] [R17]
				wait_q <= W_NONE;
			end
			// Start and stop generator, then the master bit clock.
			case (gen_q)
				G_IDLE: begin
					tmr_q <= '0;
					if (gen_take_start) begin
						gen_q <= G_START_A;
						{hold_q, gscl_low_q, sda_low_q} <= 3'h0;
					end else if (gen_take_stop) begin
						gen_q <= G_STOP_A;
						{hold_q, sda_low_q, gsda_low_q, gscl_low_q} <= 4'b0011;
					end else if (master_q && active_q && !hold_q) begin
						// The high half is timed only once the line is seen high.
						if (gscl_low_q) tmr_q <= tmr_done ? '0 : tmr_q + 1'b1;
						else if (!scl_s) tmr_q <= '0; // [R23]
						else tmr_q <= tmr_done ? '0 : tmr_q + 1'b1;
						if (tmr_done && (gscl_low_q || scl_s)) gscl_low_q <= ~gscl_low_q; // [R8]
					end
				end
				G_START_A: begin
					tmr_q <= scl_s ? tmr_q + 1'b1 : '0;
					if (scl_s && tmr_done) begin
						gsda_low_q <= 1'b1; // [R9]
						tmr_q <= '0;
						gen_q <= G_START_B;
					end
				end
				G_START_B: begin
					tmr_q <= tmr_q + 1'b1;
					if (tmr_done) begin
						{master_q, sb_q, tx_q, hold_q, gscl_low_q} <= 5'h1f; // [R7]
						wait_q <= W_SR1;
						gen_q <= G_IDLE;
					end
				end
				G_STOP_A: begin
					tmr_q <= tmr_q + 1'b1;
					if (tmr_done) begin
						gscl_low_q <= 1'b0;
						tmr_q <= '0;
						gen_q <= G_STOP_B;
					end
				end
				G_STOP_B: begin
					tmr_q <= scl_s ? tmr_q + 1'b1 : '0;
					if (scl_s && tmr_done) begin
						{gsda_low_q, master_q, active_q} <= 3'h0; // [R7] [R9]
						wait_q <= W_NONE;
						gen_q <= G_IDLE;
					end
				end
				default: gen_q <= G_IDLE;
			endcase
		end
	end

	// Pads: open drain while on, general-purpose port otherwise; all outputs registered.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			{sda_out_q, sda_oe_q, scl_out_q, scl_oe_q} <= 4'h0;
			{dma_req_q, irq_q} <= 2'b00;
			rdata_q <= 8'h00;
		end else begin
			sda_out_q <= on ? 1'b0 : gpio_sda_out; // [R2] [R3]
			sda_oe_q <= on ? (sda_low_q | gsda_low_q) : gpio_sda_oe; // [R2] [R3]
			scl_out_q <= on ? 1'b0 : gpio_scl_out; // [R2] [R3]
			scl_oe_q <= on ? (hold_q | gscl_low_q) : gpio_scl_oe; // [R2] [R3]
			dma_req_q <= on && dma_en && hold_q && (wait_q == W_WR || wait_q == W_RD) && !dma_ack; // [R17]
			irq_q <= on && ctrl_q[`I2CMM_CR_ITE] && evf; // [R18] [R21]
			rdata_q <= reg_re ? rd_val : 8'h00;
		end
	end

	assign reg_rdata = rdata_q;
	assign sda_out = sda_out_q;
	assign sda_oe = sda_oe_q;
	assign scl_out = scl_out_q;
	assign scl_oe = scl_oe_q;
	assign dma_req = dma_req_q;
	assign dma_rdata = dr_q;
	assign event_irq = irq_q;
endmodule

// File: verification/i2cmm_top_sva.sv
// Purpose: Port-level checks of the two-wire bus interface.
// Assumes: Interface state is mirrored from control writes seen at the register port.
// Notes: Bound to every instance of i2cmm_top.
`timescale 1ns/100ps
`include "i2cmm_map.svh"
module i2cmm_top_sva (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic scl_out,
	input wire logic scl_oe,
	input wire logic gpio_sda_out,
	input wire logic gpio_sda_oe,
	input wire logic gpio_scl_out,
	input wire logic gpio_scl_oe,
	input wire logic dma_req,
	input wire logic event_irq
);
	logic on_q;
	// Mirror of the enable bit on; even the first control write stores this bit.
	always_ff @(posedge clk) begin
		if (!rst_n)
			on_q <= 1'b0;
		else if (reg_we && reg_addr == `I2CMM_A_CTRL)
			on_q <= reg_wdata[`I2CMM_CR_ON];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	off_sda_a: assert property ($past(rst_n) && !$past(on_q) |->
		sda_out == $past(gpio_sda_out) && sda_oe == $past(gpio_sda_oe)) else $error("data pad not following port");
	off_scl_a: assert property ($past(rst_n) && !$past(on_q) |->
		scl_out == $past(gpio_scl_out) && scl_oe == $past(gpio_scl_oe)) else $error("clock pad not following port");
	drain_only_a: assert property ($past(on_q) |-> !sda_out && !scl_out) else $error("pad driven high");
	reset_quiet_a: assert property (!$past(rst_n) |-> !sda_oe && !scl_oe && !dma_req && !event_irq)
		else $error("output active after reset");
	rdata_idle_a: assert property (!$past(reg_re) |-> reg_rdata == 8'h00) else $error("read data outside slot");
	unmapped_rd_a: assert property ($past(reg_re) && $past(reg_addr) > 4'h8 |-> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	ctrl_msb_a: assert property ($past(reg_re) && $past(reg_addr) == `I2CMM_A_CTRL |-> !reg_rdata[7])
		else $error("control bit 7 set");
	irq_off_a: assert property (!$past(on_q) |-> !event_irq) else $error("event while off");
	dma_off_a: assert property (!$past(on_q) |-> !dma_req) else $error("transfer request while off");
endmodule

bind i2cmm_top i2cmm_top_sva u_sva (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .sda_out(sda_out), .sda_oe(sda_oe),
	.scl_out(scl_out), .scl_oe(scl_oe), .gpio_sda_out(gpio_sda_out), .gpio_sda_oe(gpio_sda_oe),
	.gpio_scl_out(gpio_scl_out), .gpio_scl_oe(gpio_scl_oe), .dma_req(dma_req), .event_irq(event_irq));

// File: verification/i2cmm_far_master.sv
// Purpose: Far-side bus master that frames starts, stops and bytes on the two lines.
// Assumes: Lines are wired-AND with pull-ups; a 1 on an output releases the line.
// Notes: The clock stands high between frames; a slave holding it low is waited for.
`timescale 1ns/100ps
module i2cmm_far_master (
	input wire logic scl_w,
	input wire logic sda_w,
	output logic scl_o,
	output logic sda_o
);
	localparam realtime HALF = 62.5;
	localparam realtime QTR = 31.2;
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// One clock pulse; data moves mid-low so it never reads as a start or stop.
	task automatic put_bit(input logic b, output logic s);
		#QTR sda_o = b;
		#QTR scl_o = 1'b1;
		wait (scl_w === 1'b1);
		s = sda_w;
		#HALF scl_o = 1'b0;
	endtask
	// Data falls while the clock is high; also serves as a repeated start.
	task automatic start_c();
		#QTR sda_o = 1'b1;
		#QTR scl_o = 1'b1;
		wait (scl_w === 1'b1);
		#HALF sda_o = 1'b0;
		#HALF scl_o = 1'b0;
	endtask
	// Data rises while the clock is high, leaving both lines released.
	task automatic stop_c();
		#QTR sda_o = 1'b0;
		#QTR scl_o = 1'b1;
		wait (scl_w === 1'b1);
		#HALF sda_o = 1'b1;
		#HALF;
	endtask
	// Eight bits high bit first, then a ninth clock with the line released for the answer.
	task automatic put_byte(input logic [7:0] b, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put_bit(b[i], s);
		put_bit(1'b1, s);
		ack = !s;
	endtask
	// Holds the data line at a level, as a rival master would.
	task automatic pull_sda(input logic b);
		sda_o = b;
	endtask
endmodule

// File: verification/tb_i2cmm_top.sv
// Purpose: Self-checking bench for the two-wire bus interface.
// Assumes: 100 MHz clock, far-side master model at a 125 ns bit period.
// Notes: Reset reads and register rows first, then slave, bus error, master and ten-bit slave scenarios.
`timescale 1ns/100ps
`include "i2cmm_map.svh"
module tb_i2cmm_top;
	typedef struct packed {logic [3:0] a; logic [7:0] d; logic [7:0] e;} i2cmm_row_t;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_we = 1'b0;
	logic reg_re = 1'b0;
	logic gp_scl_e = 1'b0;
	logic gp_sda_e = 1'b0;
	logic dma_ack = 1'b0;
	logic [7:0] reg_rdata, dma_rdata, rd;
	logic sda_out, sda_oe, scl_out, scl_oe, dma_req, event_irq, m_scl, m_sda, ack;
	// Open-drain wires: any party enabled low wins, otherwise the pull-up.
	wire sda_w = (sda_oe ? sda_out : 1'b1) & m_sda;
	wire scl_w = (scl_oe ? scl_out : 1'b1) & m_scl;
	int err_total = 0;
	int compares = 0;
	int rise_cnt = 0, start_cnt = 0, stop_cnt = 0, base;
	logic [8:0] sh = 9'h000;
	realtime rise_t = 0, hi_ns = 0;
	// Write, read back, expected: reserved bits drop, first enable keeps only the on bit.
	i2cmm_row_t rows [0:7] = '{'{4'h4, 8'ha4, 8'ha4}, '{4'h5, 8'hc0, 8'hc0}, '{4'h6, 8'hab, 8'h2b},
		'{4'h7, 8'h85, 8'h85}, '{4'h8, 8'he0, 8'he0}, '{4'ha, 8'hff, 8'h00}, '{4'h0, 8'h74, 8'h20},
		'{4'h0, 8'ha4, 8'h24}};
	// Expected answer, control value and address byte for each slave frame.
	logic [16:0] adr [0:4] = '{17'h02401, 17'h02456, 17'h13456, 17'h03401, 17'h124a4};

	i2cmm_top u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
		.reg_re(reg_re), .reg_rdata(reg_rdata), .sda_in(sda_w), .scl_in(scl_w), .sda_out(sda_out),
		.sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .gpio_sda_out(1'b0), .gpio_sda_oe(gp_sda_e),
		.gpio_scl_out(1'b0), .gpio_scl_oe(gp_scl_e), .dma_req(dma_req), .dma_ack(dma_ack),
		.dma_wdata(8'h00), .dma_rdata(dma_rdata), .event_irq(event_irq));
	i2cmm_far_master u_far (.scl_w(scl_w), .sda_w(sda_w), .scl_o(m_scl), .sda_o(m_sda));

	always #5 clk = ~clk;
	// Wire monitor: counts conditions and shifts in the data seen at each clock rise.
	always @(posedge scl_w) begin
		rise_cnt++;
		rise_t = $realtime;
		sh = {sh[7:0], sda_w};
	end
	always @(negedge scl_w) hi_ns = $realtime - rise_t;
	always @(negedge sda_w) if (scl_w) start_cnt++;
	always @(posedge sda_w) if (scl_w) stop_cnt++;

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_we <= 1'b1;
		@(posedge clk);
		reg_we <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so they are taken just past that edge.
	task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_re <= 1'b1;
		@(posedge clk);
		reg_re <= 1'b0;
		#1 d = reg_rdata;
	endtask
	task automatic wrap_up();
		$display("compares=%0d err_total=%0d", compares, err_total);
		if (err_total == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Watchdog: the whole run needs far less than this.
	initial begin
		#400000;
		err_total++;
		wrap_up();
	end

	initial begin
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 16; a++) begin
			reg_rd(4'(a), rd);
			chk(rd, 8'h00);
		end
		gp_scl_e <= 1'b1;
		repeat (6) @(posedge clk);
		chk({7'h0, scl_w}, 8'h00);
		gp_scl_e <= 1'b0;
		foreach (rows[i]) begin
			reg_wr(rows[i].a, rows[i].d);
			reg_rd(rows[i].a, rd);
			chk(rd, rows[i].e);
		end
		// Address recognition: start byte never, general call only while accepted.
		foreach (adr[i]) begin
			if (i == 3) reg_wr(`I2CMM_A_GCA, 8'h00);
			reg_wr(`I2CMM_A_CTRL, adr[i][15:8]);
			u_far.start_c();
			u_far.put_byte(adr[i][7:0], ack);
			chk({7'h0, ack}, {7'h0, adr[i][16]});
			if (ack) begin
				repeat (20) @(posedge clk);
				chk({7'h0, scl_w}, 8'h00);
				reg_rd(`I2CMM_A_STAT1, rd);
				chk(rd & 8'h08, 8'h08);
			end
			u_far.stop_c();
		end
		// Slave receive: byte held behind a stretched clock until the data register is read.
		u_far.start_c();
		u_far.put_byte(8'ha4, ack);
		repeat (20) @(posedge clk);
		reg_rd(`I2CMM_A_STAT1, rd);
		u_far.put_byte(8'h3c, ack);
		chk({7'h0, ack}, 8'h01);
		repeat (20) @(posedge clk);
		chk({7'h0, scl_w}, 8'h00);
		chk(dma_rdata, 8'h3c);
		reg_rd(`I2CMM_A_DATA, rd);
		chk(rd, 8'h3c);
		// Second byte drained by the transfer handshake instead of a register read.
		reg_wr(`I2CMM_A_CTRL, 8'h65);
		u_far.put_byte(8'h5a, ack);
		repeat (20) @(posedge clk);
		chk({6'h0, dma_req, event_irq}, 8'h03);
		dma_ack <= 1'b1;
		@(posedge clk);
		dma_ack <= 1'b0;
		chk(dma_rdata, 8'h5a);
		repeat (2) @(posedge clk);
		chk({7'h0, dma_req}, 8'h00);
		u_far.stop_c();
		reg_rd(`I2CMM_A_STAT2, rd);
		chk(rd & 8'h08, 8'h08);
		// A start after three bits is misplaced.
		u_far.start_c();
		for (int i = 0; i < 3; i++)
			u_far.put_bit(1'b1, ack);
		u_far.start_c();
		u_far.stop_c();
		reg_rd(`I2CMM_A_STAT2, rd);
		chk(rd & 8'h02, 8'h02);
		// Master: start on request, one unanswered byte, stop on request.
		base = start_cnt;
		rd = 8'h00;
		reg_wr(`I2CMM_A_CTRL, 8'h2c);
		for (int k = 0; k < 500 && !rd[1]; k++) begin
			repeat (10) @(posedge clk);
			reg_rd(`I2CMM_A_STAT1, rd);
		end
		chk(rd & 8'h06, 8'h06);
		chk(8'(start_cnt - base), 8'h01);
		base = rise_cnt;
		reg_wr(`I2CMM_A_DATA, 8'ha5);
		for (int k = 0; k < 20000 && rise_cnt < base + 9; k++)
			@(posedge clk);
		chk(8'(rise_cnt - base), 8'h09);
		chk(sh[8:1], 8'ha5);
		chk({7'h0, sh[0]}, 8'h01);
		chk({7'h0, hi_ns >= 1250.0}, 8'h01);
		base = stop_cnt;
		reg_wr(`I2CMM_A_CTRL, 8'h26);
		for (int k = 0; k < 20000 && stop_cnt == base; k++)
			@(posedge clk);
		chk(8'(stop_cnt - base), 8'h01);
		reg_rd(`I2CMM_A_STAT1, rd);
		chk(rd & 8'h04, 8'h00);
		reg_rd(`I2CMM_A_STAT2, rd);
		chk(rd & 8'h10, 8'h10);
		// Arbitration: a rival holds data low while the master sends ones.
		rd = 8'h00;
		reg_wr(`I2CMM_A_CTRL, 8'h2c);
		for (int k = 0; k < 500 && !rd[1]; k++) begin
			repeat (10) @(posedge clk);
			reg_rd(`I2CMM_A_STAT1, rd);
		end
		u_far.pull_sda(1'b0);
		reg_wr(`I2CMM_A_DATA, 8'hff);
		repeat (2000) @(posedge clk);
		reg_rd(`I2CMM_A_STAT1, rd);
		chk(rd & 8'h04, 8'h00);
		u_far.pull_sda(1'b1);
		repeat (10) @(posedge clk);
		reg_rd(`I2CMM_A_STAT2, rd);
		chk(rd & 8'h14, 8'h14);
		// Ten-bit address, set while off: header then low byte, each answered.
		reg_wr(`I2CMM_A_CTRL, 8'h00);
		reg_wr(`I2CMM_A_OWN_HI, 8'hc8);
		reg_wr(`I2CMM_A_CTRL, 8'h24);
		reg_wr(`I2CMM_A_CTRL, 8'h24);
		u_far.start_c();
		u_far.put_byte(8'hf0, ack);
		chk({7'h0, ack}, 8'h01);
		u_far.put_byte(8'ha4, ack);
		chk({7'h0, ack}, 8'h01);
		repeat (20) @(posedge clk);
		reg_rd(`I2CMM_A_STAT1, rd);
		chk(rd & 8'h08, 8'h08);
		u_far.stop_c();
		wrap_up();
	end
endmodule
